// file: hdl/fss_regs.svh
// Register map, field positions, reset values and timing counts of the fast step sequencer
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH

// Register byte offsets
`define FSS_OFF_CTRL 8'h00
`define FSS_OFF_LOOPS 8'h04
`define FSS_OFF_LAST_STEP 8'h08
`define FSS_OFF_TBASE 8'h0C
`define FSS_OFF_LAST_VAL 8'h10
`define FSS_OFF_STEP_SEL 8'h14
`define FSS_OFF_STEP_DATA 8'h18
`define FSS_OFF_CMD 8'h1C
`define FSS_OFF_FILL_VAL 8'h20
`define FSS_OFF_FILL_STEPS 8'h24
`define FSS_OFF_STATUS 8'h28
`define FSS_OFF_RUN 8'h2C

// Field positions
`define FSS_CTRL_EN 0
`define FSS_CTRL_LOAD_ON 1
`define FSS_CTRL_MODE_CR 2
`define FSS_CTRL_RANGE_LSB 3
`define FSS_CTRL_LAST_EN 6
`define FSS_CTRL_LOOP_INF 7
`define FSS_CMD_INSERT 0
`define FSS_CMD_DELETE 1
`define FSS_CMD_FILL 2
`define FSS_CMD_SRESET 3
`define FSS_STAT_ERR 19
`define FSS_STEP_TRIG 16

// Limits and reset values
`define FSS_MAX_STEPS 10'h3E8
`define FSS_MIN_STEPS 10'h003
`define FSS_LOOP_MAX 14'h270F
`define FSS_RANGE_MAX 3'h5
`define FSS_RST_LOOPS 14'h0001
`define FSS_RST_LAST_STEP 10'h3E8
`define FSS_RST_TBASE 15'h0001

// Timing: tick of 0.025 ms, time base up to 600 ms
`define FSS_CLK_KHZ 250000
`define FSS_TICK_NS 25000
`define FSS_TBASE_MAX_NS 600000000
`define FSS_TICK_CYCLES ((`FSS_TICK_NS * (`FSS_CLK_KHZ / 1000)) / 1000)
`define FSS_TBASE_MAX (`FSS_TBASE_MAX_NS / `FSS_TICK_NS)

`endif

// file: hdl/fss_pkg.sv
// Types shared by the fast step sequencer modules
package fss_pkg;

   typedef enum logic [2:0] {
      FSS_IDLE,
      FSS_RUN,
      FSS_DONE,
      FSS_DELETE,
      FSS_FILL,
      FSS_PREFILL
   } fss_state_t;

   typedef struct packed {
      fss_state_t st;
      logic ack;
      logic [31:0] rdat;
      logic en;
      logic load_on;
      logic mode_cr;
      logic [2:0] range;
      logic last_en;
      logic loop_inf;
      logic [13:0] loops;
      logic [9:0] last_step;
      logic [14:0] tbase;
      logic [15:0] last_val;
      logic [9:0] count;
      logic [9:0] sel;
      logic [15:0] fsv;
      logic [15:0] fev;
      logic [9:0] fss;
      logic [9:0] fse;
      logic farmed;
      logic [9:0] walk;
      logic [9:0] run_step;
      logic [13:0] run_loop;
      logic [15:0] presc;
      logic [14:0] tcnt;
      logic enter;
      logic complete;
      logic err;
      logic ip_start;
      logic engaged;
      logic [15:0] setpt;
      logic is_res;
      logic [2:0] rng_out;
      logic trig;
      logic ind;
   } fss_core_t;

   typedef struct packed {
      logic [999:0][16:0] mem;
   } fss_mem_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic [4:0] cnt;
      logic [25:0] quo;
      logic [10:0] rem;
      logic neg;
      logic [15:0] base;
      logic [9:0] den;
      logic [15:0] res;
   } fss_interp_t;

endpackage

// file: hdl/fss_step_mem.sv
// Step table: value and trigger flag per step, flip-flop storage
`timescale 1ns/1ns
`include "fss_regs.svh"
module fss_step_mem (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Write port
   input wire logic wr_en,
   input wire logic [9:0] wr_idx,
   input wire logic [16:0] wr_data,
   // Read ports
   input wire logic [9:0] rd_a_idx,
   output logic [16:0] rd_a_data,
   input wire logic [9:0] rd_b_idx,
   output logic [16:0] rd_b_data
);
   fss_pkg::fss_mem_t q;
   fss_pkg::fss_mem_t n;

   always_comb begin
      n = q;
      if (wr_en && wr_idx < `FSS_MAX_STEPS) begin
         n.mem[wr_idx] = wr_data;
      end
      rd_a_data = (rd_a_idx < `FSS_MAX_STEPS) ? q.mem[rd_a_idx] : 17'h00000;
      rd_b_data = (rd_b_idx < `FSS_MAX_STEPS) ? q.mem[rd_b_idx] : 17'h00000;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule

// file: hdl/fss_interp.sv
// Linear interpolator: base + (end - base) * k / span, by shift-subtract division
`timescale 1ns/1ns
module fss_interp (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Request
   input wire logic start,
   input wire logic [15:0] start_val,
   input wire logic [15:0] end_val,
   input wire logic [9:0] k,
   input wire logic [9:0] span,
   // Answer
   output logic done,
   output logic [15:0] result
);
   fss_pkg::fss_interp_t q;
   fss_pkg::fss_interp_t n;
   logic [15:0] diff;
   logic [10:0] trial;
   logic [15:0] qv;

   always_comb begin
      n = q;
      n.done = 1'b0;
      diff = (end_val >= start_val) ? end_val - start_val : start_val - end_val;
      trial = {q.rem[9:0], q.quo[25]};
      qv = q.quo[15:0];
      if (start) begin
         n.busy = 1'b1;
         n.cnt = 5'h00;
         n.rem = 11'h000;
         n.quo = 26'(diff * k);
         n.neg = end_val < start_val;
         n.base = start_val;
         n.den = span;
      end else if (q.busy) begin
         if (trial >= {1'b0, q.den}) begin
            n.rem = trial - {1'b0, q.den};
            n.quo = {q.quo[24:0], 1'b1};
         end else begin
            n.rem = trial;
            n.quo = {q.quo[24:0], 1'b0};
         end
         n.cnt = q.cnt + 5'h01;
         if (q.cnt == 5'h19) begin
            // Zero span would divide by zero; it means a single step at the start value
            qv = (q.den == 10'h000) ? 16'h0000 : n.quo[15:0];
            n.res = q.neg ? q.base - qv : q.base + qv; // RULE_12
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
      done = q.done;
      result = q.res;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule

// file: hdl/fss_seq.sv
// Fast step sequencer core with its Wishbone register file
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "fss_regs.svh"
// Function
// RULE_01: Only constant current or resistance modes allowed
// RULE_02: Table holds 1000 steps numbered from 1
// RULE_03: Every step lasts one shared time base
// RULE_04: Time base from 0.025 ms to 600 ms
// RULE_05: Loop 1 to 9999 times or forever
// RULE_06: Last load holds final value, else load released
// RULE_07: Step changes are abrupt, never ramped
// RULE_08: Last step per loop from 1 to 1000
// RULE_09: Never fewer than three steps; deletes refused
// RULE_10: Trigger pulse at start of flagged step
// RULE_11: Step value is current or resistance by mode
// RULE_12: Fill interpolates values linearly across step range
// RULE_13: Armed fill range prefills newly inserted steps
// RULE_14: Insert increments count, selects new step
// RULE_15: Only inserted steps may be selected
// RULE_16: Load on starts sequence at once when enabled
// RULE_17: Load off aborts run and stops drawing current
// RULE_18: Report active step and active loop
// RULE_19: Signal completion after all loops
// RULE_20: One of six ranges held for whole run
// RULE_21: Steps ascend to last step, then wrap
// RULE_22: Tick timer from clock; soft reset to idle
module fss_seq #(
   parameter int TICK_CYCLES = `FSS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Load set-point path
   output logic load_engaged,
   output logic [15:0] setpoint,
   output logic setpoint_is_resistance,
   output logic [2:0] range_sel,
   // Trigger terminal and status
   output logic trig_out,
   output logic fast_run_indicator,
   output logic seq_complete
);
   fss_pkg::fss_core_t q;
   fss_pkg::fss_core_t n;
   logic [16:0] rd_a;
   logic [16:0] rd_b;
   logic [9:0] rd_b_idx;
   logic mem_we;
   logic [9:0] mem_widx;
   logic [16:0] mem_wdat;
   logic ip_done;
   logic [15:0] ip_res;
   logic [31:0] rd_word;
   logic [31:0] w;
   logic req;
   logic busy;
   logic [9:0] eff_last;
   logic tick;
   logic [9:0] new_step;

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
   localparam logic [14:0] TBASE_MAX = 15'(`FSS_TBASE_MAX);

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic in_range(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   fss_step_mem u_mem (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .wr_en(mem_we),
      .wr_idx(mem_widx),
      .wr_data(mem_wdat),
      .rd_a_idx(q.sel - 10'h001),
      .rd_a_data(rd_a),
      .rd_b_idx(rd_b_idx),
      .rd_b_data(rd_b)
   );

   fss_interp u_interp (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .start(q.ip_start),
      .start_val(q.fsv),
      .end_val(q.fev),
      .k(q.walk - q.fss),
      .span(q.fse - q.fss),
      .done(ip_done),
      .result(ip_res)
   );

   always_comb begin
      n = q;
      n.ack = 1'b0;
      n.ip_start = 1'b0;
      n.trig = 1'b0;
      n.enter = 1'b0;
      n.ind = q.en;
      mem_we = 1'b0;
      mem_widx = 10'h000;
      mem_wdat = 17'h00000;
      new_step = q.count + 10'h001;
      req = wb_cyc_i & wb_stb_i & ~q.ack;
      busy = (q.st == fss_pkg::FSS_DELETE) || (q.st == fss_pkg::FSS_FILL) || (q.st == fss_pkg::FSS_PREFILL);
      eff_last = (q.last_step < q.count) ? q.last_step : q.count;
      tick = (q.presc == TICK_LAST);
      case (q.st)
         fss_pkg::FSS_DELETE: rd_b_idx = q.walk;
         fss_pkg::FSS_FILL, fss_pkg::FSS_PREFILL: rd_b_idx = q.walk - 10'h001;
         default: rd_b_idx = q.run_step - 10'h001;
      endcase

      case (wb_adr_i)
         `FSS_OFF_CTRL: rd_word = {24'h000000, q.loop_inf, q.last_en, q.range, q.mode_cr, q.load_on, q.en};
         `FSS_OFF_LOOPS: rd_word = {18'h00000, q.loops};
         `FSS_OFF_LAST_STEP: rd_word = {22'h000000, q.last_step};
         `FSS_OFF_TBASE: rd_word = {17'h00000, q.tbase};
         `FSS_OFF_LAST_VAL: rd_word = {16'h0000, q.last_val};
         `FSS_OFF_STEP_SEL: rd_word = {22'h000000, q.sel};
         `FSS_OFF_STEP_DATA: rd_word = (q.count == 10'h000) ? 32'h00000000 : {15'h0000, rd_a};
         `FSS_OFF_FILL_VAL: rd_word = {q.fev, q.fsv};
         `FSS_OFF_FILL_STEPS: rd_word = {q.farmed, 5'h00, q.fse, 6'h00, q.fss};
         `FSS_OFF_STATUS: rd_word = {11'h000, q.ind, q.err, busy, q.complete,
                                     q.st == fss_pkg::FSS_RUN, 6'h00, q.count};
         `FSS_OFF_RUN: rd_word = {2'h0, q.run_loop, 6'h00, q.run_step}; // RULE_18
         default: rd_word = 32'h00000000;
      endcase
      w = merge_bytes(rd_word, wb_dat_i, wb_sel_i);

      if (req) begin
         n.ack = 1'b1;
         n.rdat = wb_we_i ? 32'h00000000 : rd_word;
         if (wb_we_i) begin
            case (wb_adr_i)
               `FSS_OFF_CTRL: begin
                  n.en = w[`FSS_CTRL_EN];
                  n.load_on = w[`FSS_CTRL_LOAD_ON];
                  n.last_en = w[`FSS_CTRL_LAST_EN];
                  n.loop_inf = w[`FSS_CTRL_LOOP_INF];
                  // Mode and range are frozen while a run owns the load
                  if (q.st != fss_pkg::FSS_RUN) begin
                     n.mode_cr = w[`FSS_CTRL_MODE_CR]; // RULE_01
                     if (w[`FSS_CTRL_RANGE_LSB +: 3] <= `FSS_RANGE_MAX) begin
                        n.range = w[`FSS_CTRL_RANGE_LSB +: 3]; // RULE_20
                     end
                  end
               end
               `FSS_OFF_LOOPS: begin
                  if (w[13:0] != 14'h0000 && w[13:0] <= `FSS_LOOP_MAX) begin
                     n.loops = w[13:0]; // RULE_05
                  end
               end
               `FSS_OFF_LAST_STEP: begin
                  if (in_range(w[9:0], 10'h001, `FSS_MAX_STEPS)) begin
                     n.last_step = w[9:0]; // RULE_08
                  end
               end
               `FSS_OFF_TBASE: begin
                  if (w[14:0] != 15'h0000 && w[14:0] <= TBASE_MAX) begin
                     n.tbase = w[14:0]; // RULE_04
                  end
               end
               `FSS_OFF_LAST_VAL: n.last_val = w[15:0];
               `FSS_OFF_STEP_SEL: begin
                  if (in_range(w[9:0], 10'h001, q.count)) begin
                     n.sel = w[9:0]; // RULE_15
                  end else begin
                     n.err = 1'b1;
                  end
               end
               `FSS_OFF_STEP_DATA: begin
                  if (q.count != 10'h000 && !busy) begin
                     mem_we = 1'b1;
                     mem_widx = q.sel - 10'h001;
                     mem_wdat = w[16:0]; // RULE_11
                  end else begin
                     n.err = 1'b1;
                  end
               end
               `FSS_OFF_FILL_VAL: begin
                  n.fsv = w[15:0];
                  n.fev = w[31:16];
               end
               `FSS_OFF_FILL_STEPS: begin
                  n.fss = w[9:0];
                  n.fse = w[25:16];
                  n.farmed = in_range(w[9:0], 10'h001, w[25:16]) && w[25:16] <= `FSS_MAX_STEPS;
               end
               `FSS_OFF_STATUS: begin
                  if (w[`FSS_STAT_ERR]) begin
                     n.err = 1'b0;
                  end
               end
               `FSS_OFF_CMD: begin
                  if (w[`FSS_CMD_SRESET]) begin
                     // Software return to idle; step table and settings other than load_on survive
                     n.st = fss_pkg::FSS_IDLE; // RULE_22
                     n.engaged = 1'b0;
                     n.setpt = 16'h0000;
                     n.complete = 1'b0;
                     n.load_on = 1'b0;
                  end else if (busy || q.st != fss_pkg::FSS_IDLE) begin
                     n.err = q.err | (|w[2:0]);
                  end else if (w[`FSS_CMD_INSERT]) begin
                     if (q.count < `FSS_MAX_STEPS) begin // RULE_02
                        n.count = new_step; // RULE_14
                        n.sel = new_step;
                        mem_we = 1'b1;
                        mem_widx = q.count;
                        if (q.farmed && in_range(new_step, q.fss, q.fse)) begin
                           n.st = fss_pkg::FSS_PREFILL; // RULE_13
                           n.walk = new_step;
                           n.ip_start = 1'b1;
                        end
                     end else begin
                        n.err = 1'b1;
                     end
                  end else if (w[`FSS_CMD_DELETE]) begin
                     if (q.count <= `FSS_MIN_STEPS) begin
                        n.err = 1'b1; // RULE_09
                     end else begin
                        n.st = fss_pkg::FSS_DELETE;
                        n.walk = q.sel;
                     end
                  end else if (w[`FSS_CMD_FILL]) begin
                     if (q.farmed && q.fss <= q.count) begin
                        n.st = fss_pkg::FSS_FILL; // RULE_12
                        n.walk = q.fss;
                        n.ip_start = 1'b1;
                     end else begin
                        n.err = 1'b1;
                     end
                  end
               end
               default: ;
            endcase
         end
      end

      // Value of a step reaches the load in the cycle after it becomes active
      if (q.enter) begin
         n.setpt = rd_b[15:0]; // RULE_07
         n.trig = rd_b[`FSS_STEP_TRIG]; // RULE_10
      end

      case (q.st)
         fss_pkg::FSS_IDLE: begin
            if (q.en && q.load_on && q.count >= `FSS_MIN_STEPS && !n.ip_start) begin
               n.st = fss_pkg::FSS_RUN; // RULE_16
               n.run_step = 10'h001;
               n.run_loop = 14'h0001;
               n.presc = 16'h0000;
               n.tcnt = 15'h0000;
               n.enter = 1'b1;
               n.engaged = 1'b1;
               n.complete = 1'b0;
               n.rng_out = q.range; // RULE_20
               n.is_res = q.mode_cr; // RULE_11
            end
         end
         fss_pkg::FSS_RUN: begin
            if (!n.load_on || !n.en) begin
               n.st = fss_pkg::FSS_IDLE; // RULE_17
               n.engaged = 1'b0;
               n.setpt = 16'h0000;
               n.trig = 1'b0;
            end else begin
               n.presc = tick ? 16'h0000 : q.presc + 16'h0001; // RULE_22
               if (tick) begin
                  n.tcnt = q.tcnt + 15'h0001;
                  if (q.tcnt + 15'h0001 >= q.tbase) begin
                     n.tcnt = 15'h0000; // RULE_03
                     if (q.run_step >= eff_last) begin
                        if (!q.loop_inf && q.run_loop >= q.loops) begin
                           n.st = fss_pkg::FSS_DONE; // RULE_19
                        end else begin
                           n.run_step = 10'h001; // RULE_21
                           n.enter = 1'b1;
                           if (q.run_loop < `FSS_LOOP_MAX) begin
                              n.run_loop = q.run_loop + 14'h0001; // RULE_05
                           end
                        end
                     end else begin
                        n.run_step = q.run_step + 10'h001; // RULE_21
                        n.enter = 1'b1;
                     end
                  end
               end
            end
         end
         fss_pkg::FSS_DONE: begin
            if (!n.load_on || !n.en) begin
               n.st = fss_pkg::FSS_IDLE; // RULE_17
               n.engaged = 1'b0;
               n.setpt = 16'h0000;
            end else if (!q.complete) begin
               n.complete = 1'b1; // RULE_19
               n.engaged = q.last_en; // RULE_06
               n.setpt = q.last_en ? q.last_val : 16'h0000; // RULE_06
            end
         end
         fss_pkg::FSS_DELETE: begin
            // One entry moves down per cycle; a full table takes up to 1000 cycles
            if (q.walk < q.count) begin
               mem_we = 1'b1;
               mem_widx = q.walk - 10'h001;
               mem_wdat = rd_b;
               n.walk = q.walk + 10'h001;
            end else begin
               n.count = q.count - 10'h001;
               n.sel = (q.sel > q.count - 10'h001) ? q.count - 10'h001 : q.sel;
               n.st = fss_pkg::FSS_IDLE;
            end
         end
         fss_pkg::FSS_FILL, fss_pkg::FSS_PREFILL: begin
            if (ip_done) begin
               mem_we = 1'b1;
               mem_widx = q.walk - 10'h001;
               mem_wdat = {rd_b[`FSS_STEP_TRIG], ip_res}; // RULE_12
               if (q.st == fss_pkg::FSS_FILL && q.walk < q.fse && q.walk < q.count) begin
                  n.walk = q.walk + 10'h001;
                  n.ip_start = 1'b1;
               end else begin
                  n.st = fss_pkg::FSS_IDLE;
               end
            end
         end
         default: n.st = fss_pkg::FSS_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.st <= fss_pkg::FSS_IDLE;
         q.loops <= `FSS_RST_LOOPS;
         q.last_step <= `FSS_RST_LAST_STEP;
         q.tbase <= `FSS_RST_TBASE;
      end else begin
         q <= n;
      end
   end

   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign load_engaged = q.engaged;
   assign setpoint = q.setpt;
   assign setpoint_is_resistance = q.is_res;
   assign range_sel = q.rng_out;
   assign trig_out = q.trig;
   assign fast_run_indicator = q.ind;
   assign seq_complete = q.complete;
endmodule

// file: verif/fss_seq_chk.sv
// Port assertions for the fast step sequencer
`timescale 1ns/1ns
module fss_seq_chk #(
   parameter int TICK_CYCLES = 6250
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Register bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Load path and status
   input wire logic load_engaged,
   input wire logic [15:0] setpoint,
   input wire logic setpoint_is_resistance,
   input wire logic [2:0] range_sel,
   input wire logic trig_out,
   input wire logic fast_run_indicator,
   input wire logic seq_complete
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_one_cycle: assert property (s_req |=> s_ack)
      else $error("ack timing wrong");
   a_wr_dat_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
      else $error("write ack carried data");
   a_idle_setpt_zero: assert property (!load_engaged |-> setpoint == 16'h0)
      else $error("set point while released");
   a_trig_pulse: assert property (trig_out |=> !trig_out)
      else $error("trigger longer than one cycle");
   a_trig_in_run: assert property (trig_out |-> load_engaged)
      else $error("trigger outside a run");
   a_range_legal: assert property (range_sel <= 3'h5)
      else $error("range code out of set");
   a_range_hold: assert property (load_engaged && $past(load_engaged) |->
      $stable(range_sel) && $stable(setpoint_is_resistance))
      else $error("range or mode moved in run");
   a_run_ind: assert property (load_engaged |-> fast_run_indicator)
      else $error("engaged without indicator");
   a_cmpl_cause: assert property ($rose(seq_complete) |-> $past(load_engaged))
      else $error("completion without a run");
endmodule
bind fss_seq fss_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .load_engaged(load_engaged), .setpoint(setpoint),
   .setpoint_is_resistance(setpoint_is_resistance), .range_sel(range_sel), .trig_out(trig_out),
   .fast_run_indicator(fast_run_indicator), .seq_complete(seq_complete)
);

// file: verif/fss_load_model.sv
// Supply under test, drawing what the load asks for
`timescale 1ns/1ns
module fss_load_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Load path
   input wire logic load_engaged,
   input wire logic [15:0] setpoint,
   input wire logic trig_out,
   // Observed draw and trigger count
   output logic [15:0] drawn,
   output logic [7:0] trig_cnt
);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         drawn <= 16'h0000;
         trig_cnt <= 8'h00;
      end else begin
         drawn <= load_engaged ? setpoint : 16'h0000;
         trig_cnt <= trig_cnt + {7'h00, trig_out};
      end
   end
endmodule

// file: verif/tb_fss_seq.sv
// Self-checking bench for the fast step sequencer
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_fss_seq;
   typedef struct packed {logic [7:0] a; logic [31:0] r; logic [31:0] w; logic [31:0] e;} fss_row_t;
   logic sys_clk = 1'b0, nrst = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] q_o, q;
   logic ack, eng, is_res, trig, ind, cmpl;
   logic [15:0] sp, drawn, last_sp = 16'h0;
   logic [2:0] rng;
   logic [7:0] trig_cnt;
   int checks = 0, n_fail = 0, cyc_n = 0, i, k;
   logic [15:0] sp_q[$];
   int t_q[$];
   logic [15:0] exp_sp [7] = '{16'h000A, 16'h0014, 16'h001E, 16'h000A, 16'h0014, 16'h001E, 16'h0055};
   fss_row_t rows [9] = '{'{8'h04, 32'h1, 32'h0, 32'h1}, '{8'h04, 32'h1, 32'h270F, 32'h270F},
      '{8'h04, 32'h270F, 32'h2710, 32'h270F}, '{8'h08, 32'h3E8, 32'h3E9, 32'h3E8},
      '{8'h08, 32'h3E8, 32'h0, 32'h3E8}, '{8'h0C, 32'h1, 32'h5DC1, 32'h1},
      '{8'h0C, 32'h1, 32'h5DC0, 32'h5DC0}, '{8'h30, 32'h0, 32'hFFFF, 32'h0}, '{8'h28, 32'h0, 32'h3FF, 32'h0}};
   always #2 sys_clk = ~sys_clk;
   fss_seq #(.TICK_CYCLES(4)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q_o), .wb_ack_o(ack),
      .load_engaged(eng), .setpoint(sp), .setpoint_is_resistance(is_res), .range_sel(rng),
      .trig_out(trig), .fast_run_indicator(ind), .seq_complete(cmpl));
   fss_load_model mdl_u (.sys_clk(sys_clk), .nrst(nrst), .load_engaged(eng), .setpoint(sp),
      .trig_out(trig), .drawn(drawn), .trig_cnt(trig_cnt));
   // Record every set point change with its cycle number
   always @(posedge sys_clk) begin
      cyc_n++;
      if (nrst && sp !== last_sp) begin
         sp_q.push_back(sp);
         t_q.push_back(cyc_n);
         last_sp = sp;
      end
   end
   task final_report;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int j;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      for (j = 0; j < 50; j++) begin
         @(posedge sys_clk);
         if (ack === 1'b1) break;
      end
      r = q_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (j == 50) begin
         n_fail++;
         final_report();
      end
   endtask
   task automatic wait_idle;
      int j;
      for (j = 0; j < 100; j++) begin
         wb(1'b0, 8'h28, 32'h0, q);
         if (q[18] === 1'b0) break;
      end
      if (j == 100) begin
         n_fail++;
         final_report();
      end
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      foreach (rows[r]) begin
         wb(1'b0, rows[r].a, 32'h0, q);
         `CHK("reg_before", rows[r].r, q);
         wb(1'b1, rows[r].a, rows[r].w, q);
         wb(1'b0, rows[r].a, 32'h0, q);
         `CHK("reg_after", rows[r].e, q);
      end
      wb(1'b1, 8'h14, 32'h1, q);
      wb(1'b0, 8'h28, 32'h0, q);
      `CHK("sel_empty_err", 1'b1, q[19]);
      wb(1'b1, 8'h28, 32'h80000, q);
      for (k = 0; k < 3; k++) begin
         wb(1'b1, 8'h1C, 32'h1, q);
         wait_idle();
      end
      `CHK("count", 10'h003, q[9:0]);
      wb(1'b0, 8'h14, 32'h0, q);
      `CHK("sel_new", 32'h3, q);
      wb(1'b1, 8'h1C, 32'h2, q);
      wb(1'b0, 8'h28, 32'h0, q);
      `CHK("del_refused", 2'b11, {q[19], q[0]});
      `CHK("del_count", 10'h003, q[9:0]);
      wb(1'b1, 8'h28, 32'h80000, q);
      wb(1'b1, 8'h14, 32'h1, q);
      wb(1'b1, 8'h18, 32'h10000, q);
      wb(1'b1, 8'h20, 32'h0028000A, q);
      wb(1'b1, 8'h24, 32'h00040001, q);
      wb(1'b1, 8'h1C, 32'h1, q);
      wait_idle();
      wb(1'b0, 8'h18, 32'h0, q);
      `CHK("prefill", 32'h28, q);
      wb(1'b1, 8'h1C, 32'h4, q);
      wait_idle();
      wb(1'b1, 8'h14, 32'h3, q);
      wb(1'b0, 8'h18, 32'h0, q);
      `CHK("fill_mid", 32'h1E, q);
      wb(1'b1, 8'h14, 32'h1, q);
      wb(1'b0, 8'h18, 32'h0, q);
      `CHK("fill_trig_kept", 32'h1000A, q);
      wb(1'b1, 8'h04, 32'h2, q);
      wb(1'b1, 8'h08, 32'h3, q);
      wb(1'b1, 8'h0C, 32'h1, q);
      wb(1'b1, 8'h10, 32'h55, q);
      wb(1'b1, 8'h00, 32'h6F, q);
      #1;
      `CHK("engaged_at_once", 2'b11, {eng, ind});
      `CHK("range", 3'h5, rng);
      `CHK("is_res", 1'b1, is_res);
      for (i = 0; i < 200 && cmpl !== 1'b1; i++) @(posedge sys_clk);
      #1;
      `CHK("complete", 1'b1, cmpl);
      `CHK("steps_seen", 7, sp_q.size());
      for (k = 0; k < 7 && k < sp_q.size(); k++) `CHK("step_val", exp_sp[k], sp_q[k]);
      for (k = 0; k < 6 && k < sp_q.size() - 1; k++) `CHK("step_len", 4, t_q[k + 1] - t_q[k]);
      `CHK("last_held", 1'b1, eng);
      `CHK("last_drawn", 16'h0055, drawn);
      `CHK("trig_count", 8'h02, trig_cnt);
      wb(1'b0, 8'h2C, 32'h0, q);
      `CHK("run_pos", 32'h00020003, q);
      wb(1'b1, 8'h00, 32'h0, q);
      wb(1'b1, 8'h00, 32'hEF, q);
      repeat (40) @(posedge sys_clk);
      #1;
      `CHK("inf_running", 2'b10, {eng, cmpl});
      wb(1'b1, 8'h00, 32'h1, q);
      #1;
      `CHK("abort", 1'b0, eng);
      @(posedge sys_clk);
      #1;
      `CHK("abort_draw", 16'h0000, drawn);
      wb(1'b1, 8'h00, 32'h6F, q);
      wb(1'b1, 8'h1C, 32'h8, q);
      #1;
      `CHK("sreset_idle", 2'b00, {eng, cmpl});
      wb(1'b0, 8'h00, 32'h0, q);
      `CHK("sreset_load_on", 1'b0, q[1]);
      final_report();
   end
endmodule
